/* File: bwd_pkg.sv */
// Package for the byte-wide window decoder: window codes, register map, reset values
// Summary of operation
// - Four windows: off, D 64K, E 64K, D-E 128K
// - Enabled target claims whole window, fitted or not
// - Paging reaches parts up to 1M bytes
// - A16-A19 come from software page value
// - Paging only in 64K window, 64K pages
// - 128K window maps contiguous, no paging
// - Small parts alias across the window
// - Socket and flash never enabled together
// - Enabling one target disables the other
// - Flash uses same window and paging
// - Flash first 64K reserved for firmware
// - Socket accesses are 8-bit byte cycles
// - Window, base and enable are software configurable
package bwd_pkg;
  // Window selections
  typedef enum logic [1:0] {
    BWD_WIN_OFF  = 2'h0,
    BWD_WIN_D64  = 2'h1,
    BWD_WIN_E64  = 2'h3,
    BWD_WIN_D128 = 2'h2
  } bwd_win_t;
  // Window bases, upper nibble of a 20-bit address (A19..A16)
  localparam logic [3:0] BWD_SEG_D = 4'hd;
  localparam logic [3:0] BWD_SEG_E = 4'he;
  // Register byte offsets
  localparam logic [3:0] BWD_OFF_CTRL = 4'h0;
  localparam logic [3:0] BWD_OFF_PAGE = 4'h4;
  localparam logic [3:0] BWD_OFF_SIZE = 4'h8;
  // Control field positions
  localparam int BWD_CTRL_WIN_LSB = 0;
  localparam int BWD_CTRL_SOCK_BIT = 2;
  localparam int BWD_CTRL_FLASH_BIT = 3;
  // Size field: log2 of fitted part size in bytes, 13..20
  localparam logic [4:0] BWD_SIZE_MIN = 5'h0d;
  localparam logic [4:0] BWD_SIZE_MAX = 5'h14;
  // Reset values, and the flash page reserved for firmware
  localparam logic [3:0] BWD_RST_PAGE = 4'h0;
  localparam logic [4:0] BWD_RST_SIZE = 5'h14;
  localparam logic [3:0] BWD_FW_PAGE = 4'h0;
endpackage

/* File: bwd_decoder.sv */
// Byte-wide window decoder: Wishbone registers plus host memory window decode
`timescale 1ns/1ps
module bwd_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave, configuration registers
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host expansion-bus memory cycle
  input wire logic mem_req_i,
  input wire logic [19:0] mem_adr_i,
  input wire logic mem_wide_i,
  // Decode results toward the memory targets
  output logic mem_claim_o,
  output logic sock_sel_o,
  output logic flash_sel_o,
  output logic [19:0] dev_adr_o,
  output logic byte_cycle_o,
  output logic fw_area_o
);

  // Configuration state
  bwd_pkg::bwd_win_t win_reg;
  logic sock_en_reg;
  logic flash_en_reg;
  logic [3:0] page_reg;
  logic [4:0] size_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // Window hit for a given address and window code
  function automatic logic win_hit(input bwd_pkg::bwd_win_t w, input logic [3:0] seg);
    unique case (w)
      bwd_pkg::BWD_WIN_OFF:  win_hit = 1'b0;
      bwd_pkg::BWD_WIN_D64:  win_hit = (seg == bwd_pkg::BWD_SEG_D);
      bwd_pkg::BWD_WIN_E64:  win_hit = (seg == bwd_pkg::BWD_SEG_E);
      bwd_pkg::BWD_WIN_D128: win_hit = (seg == bwd_pkg::BWD_SEG_D) || (seg == bwd_pkg::BWD_SEG_E);
    endcase
  endfunction

  // Mask of address bits actually wired to a part of 2**sz bytes
  function automatic logic [19:0] size_mask(input logic [4:0] sz);
    logic [4:0] s;
    s = sz;
    if (s < bwd_pkg::BWD_SIZE_MIN) begin
      s = bwd_pkg::BWD_SIZE_MIN;
    end
    if (s > bwd_pkg::BWD_SIZE_MAX) begin
      s = bwd_pkg::BWD_SIZE_MAX;
    end
    size_mask = 20'(({21'h0_0001} << s) - 21'h0_0001);
  endfunction

  // Bus access strobes, one-cycle ack so each request is taken once
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // Ack answers every address, unmapped ones included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // Window selection register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_reg <= bwd_pkg::BWD_WIN_OFF;
    end else if (wb_wr && wb_adr_i == bwd_pkg::BWD_OFF_CTRL) begin
      win_reg <= bwd_pkg::bwd_win_t'(wb_dat_i[bwd_pkg::BWD_CTRL_WIN_LSB +: 2]);
    end
  end

  // Target enables; a write asking for both keeps flash, socket drops out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sock_en_reg <= 1'b0;
      flash_en_reg <= 1'b0;
    end else if (wb_wr && wb_adr_i == bwd_pkg::BWD_OFF_CTRL) begin
      flash_en_reg <= wb_dat_i[bwd_pkg::BWD_CTRL_FLASH_BIT];
      sock_en_reg <= wb_dat_i[bwd_pkg::BWD_CTRL_SOCK_BIT] && !wb_dat_i[bwd_pkg::BWD_CTRL_FLASH_BIT];
    end
  end

  // Page register, synthesized A16..A19
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_reg <= bwd_pkg::BWD_RST_PAGE;
    end else if (wb_wr && wb_adr_i == bwd_pkg::BWD_OFF_PAGE) begin
      page_reg <= wb_dat_i[3:0];
    end
  end

  // Fitted part size, sets how many address lines reach the socket
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      size_reg <= bwd_pkg::BWD_RST_SIZE;
    end else if (wb_wr && wb_adr_i == bwd_pkg::BWD_OFF_SIZE) begin
      size_reg <= wb_dat_i[4:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        bwd_pkg::BWD_OFF_CTRL: rdat_reg <= {28'h000_0000, flash_en_reg, sock_en_reg, win_reg};
        bwd_pkg::BWD_OFF_PAGE: rdat_reg <= {28'h000_0000, page_reg};
        bwd_pkg::BWD_OFF_SIZE: rdat_reg <= {27'h000_0000, size_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;

  // Combinational decode of the current host address
  logic hit;
  logic [19:0] raw_adr;
  logic [19:0] eff_adr;
  always_comb begin
    hit = mem_req_i && (sock_en_reg || flash_en_reg) && win_hit(win_reg, mem_adr_i[19:16]);
    if (win_reg == bwd_pkg::BWD_WIN_D128) begin
      raw_adr = {3'h0, mem_adr_i[16:0]};
    end else begin
      raw_adr = {page_reg, mem_adr_i[15:0]};
    end
    // Socket lines above the part size float, so contents repeat
    eff_adr = sock_en_reg ? (raw_adr & size_mask(size_reg)) : raw_adr;
  end

  // Registered decode outputs, one clock behind the host address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_claim_o <= 1'b0;
      sock_sel_o <= 1'b0;
      flash_sel_o <= 1'b0;
      dev_adr_o <= 20'h0_0000;
      byte_cycle_o <= 1'b0;
      fw_area_o <= 1'b0;
    end else begin
      mem_claim_o <= hit;
      sock_sel_o <= hit && sock_en_reg;
      flash_sel_o <= hit && flash_en_reg;
      dev_adr_o <= eff_adr;
      byte_cycle_o <= hit && sock_en_reg && mem_wide_i;
      fw_area_o <= hit && flash_en_reg && (eff_adr[19:16] == bwd_pkg::BWD_FW_PAGE);
    end
  end

endmodule

/* File: bwd_properties.sv */
// Port-level checks for the byte-wide window decoder
`timescale 1ns/1ps
module bwd_checker (
  // Clock, reset and Wishbone handshake
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // Host cycle
  input wire logic [19:0] mem_adr_i,
  input wire logic mem_wide_i,
  // Decode results
  input wire logic mem_claim_o, sock_sel_o, flash_sel_o, byte_cycle_o, fw_area_o,
  input wire logic [19:0] dev_adr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  one_target_a: assert property (!(sock_sel_o && flash_sel_o)) else $error("two targets");
  claim_target_a: assert property (mem_claim_o == (sock_sel_o || flash_sel_o)) else $error("claim");
  claim_window_a: assert property (mem_claim_o |-> $past(mem_adr_i[19:17]) == 3'h6 ||
    $past(mem_adr_i[19:16]) == 4'he) else $error("window");
  // Flash is never size-masked, so the offset passes through
  flash_offset_a: assert property (flash_sel_o |-> dev_adr_o[15:0] == $past(mem_adr_i[15:0]))
    else $error("offset");
  byte_split_a: assert property (byte_cycle_o |-> sock_sel_o && $past(mem_wide_i)) else $error("split");
  fw_flash_a: assert property (fw_area_o |-> flash_sel_o) else $error("firmware");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
endmodule
bind bwd_decoder bwd_checker bwd_checker_inst (.*);

/* File: bwd_host.sv */
// Expansion-bus host issuing single memory cycles
`timescale 1ns/1ps
module bwd_host (
  // Clock
  input wire logic clk_i,
  // Host cycle toward the decoder
  output logic mem_req_o,
  output logic [19:0] mem_adr_o,
  output logic mem_wide_o
);
  // Idle bus shows the inverse of the last cycle, never a stale copy
  task automatic access(input logic [19:0] a, input logic w);
    @(posedge clk_i);
    mem_req_o <= 1'b1;
    mem_adr_o <= a;
    mem_wide_o <= w;
    @(posedge clk_i);
    mem_req_o <= 1'b0;
    mem_adr_o <= ~a;
    mem_wide_o <= ~w;
  endtask
  // Bus idle at time zero
  initial begin
    mem_req_o = 1'b0;
    mem_adr_o = 20'h0_0000;
    mem_wide_o = 1'b0;
  end
endmodule

/* File: bwd_testbench.sv */
// Bench: Wishbone set-up and random host cycles against the decoder
`timescale 1ns/1ps
module testbench;
  // Design and bench signals
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, pg;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic wb_ack_o, mem_req_i, mem_wide_i, mem_claim_o, sock_sel_o, flash_sel_o, byte_cycle_o, fw_area_o, es, ef, hit;
  logic [19:0] mem_adr_i, dev_adr_o, a;
  logic [15:0] lfsr = 16'h471f; // Seed 18207
  logic [1:0] win;
  logic [4:0] sz;
  int errors = 0, check_count = 0;
  bwd_decoder bwd_decoder_inst (.*);
  bwd_host bwd_host_inst (.clk_i(clk_i), .mem_req_o(mem_req_i), .mem_adr_o(mem_adr_i), .mem_wide_o(mem_wide_i));
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Socket parts smaller than the window alias by dropping high bits
  function automatic logic [19:0] exp_adr(input logic [19:0] x, input logic [1:0] w, input logic [3:0] p,
    input logic [4:0] s, input logic k);
    logic [19:0] r;
    r = (w == 2'h2) ? {3'b000, x[16:0]} : {p, x[15:0]};
    return k ? r & ((20'h0_0001 << s) - 20'h0_0001) : r;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [3:0] ad, input logic [3:0] sl, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, ad, sl, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic finish_test();
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #50000;
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({mem_claim_o, sock_sel_o, flash_sel_o, wb_ack_o}, 0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 4'(4 * i), 4'hf, 0);
      chk(rd, i == 2 ? 32'h0000_0014 : 0);
    end
    wb(1'b1, 4'h0, 4'h0, 32'h0000_000f);
    wb(1'b0, 4'h0, 4'hf, 0);
    chk(rd, 0);
    repeat (40) begin
      lfsr = nx(lfsr);
      {ef, win, pg, sz} = {lfsr[3], lfsr[1:0], lfsr[7:4], lfsr[12:8]};
      es = lfsr[2] & ~ef;
      wb(1'b1, 4'h0, 4'h1, {28'h0, lfsr[3:0]});
      wb(1'b0, 4'h0, 4'hf, 0);
      chk(rd, {28'h0, ef, es, win});
      wb(1'b1, 4'h4, 4'h1, {28'h0, pg});
      wb(1'b1, 4'h8, 4'h1, {27'h0, sz});
      // Size reads back as written; only the address mask is clamped
      wb(1'b0, 4'h8, 4'hf, 0);
      chk(rd, {27'h0, sz});
      sz = sz < 13 ? 5'h0d : (sz > 20 ? 5'h14 : sz);
      repeat (8) begin
        lfsr = nx(lfsr);
        a = {4'hc + {2'b00, lfsr[1:0]}, lfsr};
        bwd_host_inst.access(a, lfsr[5]);
        #1;
        // D window codes 1 and 2, E window codes 3 and 2
        hit = (es | ef) & (a[19:16] == 4'hd & ^win | a[19:16] == 4'he & win[1]);
        chk({mem_claim_o, sock_sel_o, flash_sel_o, byte_cycle_o}, {hit, hit & es, hit & ef, hit & es & lfsr[5]});
        if (hit) chk(dev_adr_o, exp_adr(a, win, pg, sz, es));
        if (win != 2'h2) chk(fw_area_o, hit & ef & (pg == 4'h0));
      end
    end
    finish_test();
  end
endmodule
